/* File: include/usdp_pkg.sv */
// Constants, types and register map of the shadow receive/transmit data port
// Contract
// RULE1 - Data alias spans sixteen 32-bit word locations
// RULE2 - Read bits 7:0 give received byte
// RULE3 - Master trusts read data only when ready
// RULE4 - FIFOs off: new byte overwrites, flags overrun
// RULE5 - FIFOs on: read returns oldest receive entry
// RULE6 - Receive FIFO full: drop new, flag overrun
// RULE7 - Written bytes go out serial or infrared
// RULE8 - Master writes only while holding-empty set
// RULE9 - FIFOs off: one write clears holding-empty
// RULE10 - FIFOs off: extra write overwrites pending byte
// RULE11 - FIFOs on: accept depth characters, default sixteen
// RULE12 - Transmit write while FIFO full is discarded
// RULE13 - Bits 31:8 read zero, writes ignored
package usdp_pkg;
  localparam int ADDR_W = 8;
  // Byte offsets
  localparam logic [7:0] OFF_WIN_FIRST = 8'h00;
  localparam logic [7:0] OFF_WIN_LAST = 8'h3c;
  localparam logic [7:0] OFF_FIFO_CTRL = 8'h40;
  localparam logic [7:0] OFF_LINE_STAT = 8'h44;
  localparam logic [7:0] OFF_INT_STAT = 8'h48;
  localparam logic [7:0] OFF_INT_MASK = 8'h4c;
  // fifo_control_reg fields
  localparam int FC_FIFO_EN = 0;
  localparam int FC_IR_MODE = 1;
  localparam logic [1:0] FIFO_CTRL_RST = 2'h0;
  // line_status_reg fields
  localparam int LS_DATA_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_THR_EMPTY = 5;
  localparam int LS_TX_IDLE = 6;
  // Interrupt status and mask fields
  localparam int IS_RX_AVAIL = 0;
  localparam int IS_OVERRUN = 1;
  localparam int IS_TX_EMPTY = 2;
  localparam logic [2:0] INT_MASK_RST = 3'h0;
  // Timing and FIFO depth
  localparam int CLK_NS = 50;
  localparam int BIT_NS = 800;
  localparam int BIT_CYC = BIT_NS / CLK_NS;
  localparam int IR_PULSE_CYC = (BIT_CYC * 3) / 16;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } usdp_bus_type;

  typedef enum logic [1:0] {
    ST_IDLE, ST_START, ST_DATA, ST_STOP
  } usdp_state_type;
endpackage

/* File: design/usdp_data_port.sv */
// Shadow receive/transmit data window with FIFOs and serial engines
`timescale 1ns/1ps
module usdp_data_port #(
  parameter int DEPTH = usdp_pkg::FIFO_DEPTH,
  parameter int CLK_PER_BIT = usdp_pkg::BIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input usdp_pkg::usdp_bus_type bus,
  output logic [31:0] rd_data,
  input wire logic serial_in,
  input wire logic ir_in,
  output logic serial_out,
  output logic ir_out_n,
  output logic irq
);
  import usdp_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);
  localparam logic [15:0] BIT_LAST = 16'(CLK_PER_BIT - 1);
  localparam logic [15:0] HALF_LAST = 16'(CLK_PER_BIT / 2 - 1);
  localparam logic [15:0] IR_EDGE = 16'(CLK_PER_BIT - 1 - IR_PULSE_CYC);

  // Bus decode
  logic win_hit, win_rd, win_wr;
  assign win_hit = (bus.addr <= OFF_WIN_LAST) && (bus.addr[1:0] == 2'h0);
  assign win_rd = bus.rd && win_hit; // [RULE1]
  assign win_wr = bus.wr && win_hit; // [RULE1]

  // Control and status registers
  logic [1:0] fctl_r, fctl_nxt;
  logic [2:0] ist_r, ist_nxt, imask_r, imask_nxt;
  logic ovr_r, ovr_nxt, irq_r, irq_nxt;
  logic fifo_en, ir_mode, fen_chg;
  assign fifo_en = fctl_r[FC_FIFO_EN];
  assign ir_mode = fctl_r[FC_IR_MODE];

  // Pin synchronisers
  logic ser_s1_r, ser_s2_r, ir_s1_r, ir_s2_r, rx_line;
  // Infrared receiver drives a high level for a zero bit
  assign rx_line = ir_mode ? ~ir_s2_r : ser_s2_r; // [RULE2]

  // Receive engine
  usdp_state_type rx_st_r, rx_st_nxt;
  logic [15:0] rx_tm_r, rx_tm_nxt;
  logic [2:0] rx_bit_r, rx_bit_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic rx_done;

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_tm_nxt = rx_tm_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    rx_done = 1'b0;
    if (rx_tm_r != 16'h0) begin
      rx_tm_nxt = rx_tm_r - 16'h1;
    end
    case (rx_st_r)
      ST_IDLE: begin
        if (!rx_line) begin
          rx_st_nxt = ST_START;
          rx_tm_nxt = HALF_LAST;
        end
      end
      ST_START: begin
        if (rx_tm_r == 16'h0) begin
          rx_st_nxt = rx_line ? ST_IDLE : ST_DATA;
          rx_tm_nxt = BIT_LAST;
          rx_bit_nxt = 3'h0;
        end
      end
      ST_DATA: begin
        if (rx_tm_r == 16'h0) begin
          rx_sh_nxt = {rx_line, rx_sh_r[7:1]};
          rx_bit_nxt = rx_bit_r + 3'h1;
          rx_tm_nxt = BIT_LAST;
          if (rx_bit_r == 3'h7) begin
            rx_st_nxt = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        if (rx_tm_r == 16'h0) begin
          // A bad stop bit drops the character
          rx_done = rx_line; // [RULE2]
          rx_st_nxt = ST_IDLE;
        end
      end
      default: rx_st_nxt = ST_IDLE;
    endcase
  end

  // Receive FIFO; with FIFOs off it is a one-entry buffer
  logic [7:0] rx_mem [DEPTH];
  logic [PW-1:0] rx_rd_r, rx_rd_nxt, rx_wr_r, rx_wr_nxt, rx_wa;
  logic [CW-1:0] rx_cnt_r, rx_cnt_nxt;
  logic rx_pop, rx_we, rx_ovr;
  logic [7:0] rx_head;
  assign rx_head = rx_mem[rx_rd_r];
  assign rx_pop = win_rd && (rx_cnt_r != '0);

  always_comb begin
    rx_rd_nxt = rx_rd_r;
    rx_wr_nxt = rx_wr_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_we = 1'b0;
    rx_wa = rx_wr_r;
    rx_ovr = 1'b0;
    if (!fifo_en) begin
      rx_wa = rx_rd_r;
      rx_we = rx_done; // [RULE4]
      rx_ovr = rx_done && (rx_cnt_r != '0) && !rx_pop; // [RULE4]
      if (rx_done) begin
        rx_cnt_nxt = ONE;
      end else if (rx_pop) begin
        rx_cnt_nxt = '0;
      end
    end else begin
      rx_we = rx_done && ((rx_cnt_r != FULL) || rx_pop);
      rx_ovr = rx_done && !rx_we; // [RULE6]
      if (rx_we) begin
        rx_wr_nxt = PW'(rx_wr_r + 1'b1);
      end
      if (rx_pop) begin
        rx_rd_nxt = PW'(rx_rd_r + 1'b1); // [RULE5]
      end
      rx_cnt_nxt = rx_cnt_r + CW'(rx_we) - CW'(rx_pop);
    end
    if (fen_chg) begin
      rx_rd_nxt = '0;
      rx_wr_nxt = '0;
      rx_cnt_nxt = '0;
    end
  end

  // Transmit FIFO; with FIFOs off it is the single holding register
  logic [7:0] tx_mem [DEPTH];
  logic [PW-1:0] tx_rd_r, tx_rd_nxt, tx_wr_r, tx_wr_nxt, tx_wa;
  logic [CW-1:0] tx_cnt_r, tx_cnt_nxt;
  logic tx_pop, tx_we, thr_empty;
  logic [7:0] tx_head;
  assign tx_head = tx_mem[tx_rd_r];
  assign thr_empty = (tx_cnt_r == '0);

  always_comb begin
    tx_rd_nxt = tx_rd_r;
    tx_wr_nxt = tx_wr_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_we = 1'b0;
    tx_wa = tx_wr_r;
    if (!fifo_en) begin
      tx_wa = tx_rd_r;
      tx_we = win_wr; // [RULE10]
      if (win_wr) begin
        tx_cnt_nxt = ONE; // [RULE9]
      end else if (tx_pop) begin
        tx_cnt_nxt = '0;
      end
    end else begin
      tx_we = win_wr && (tx_cnt_r != FULL); // [RULE11] [RULE12]
      if (tx_we) begin
        tx_wr_nxt = PW'(tx_wr_r + 1'b1);
      end
      if (tx_pop) begin
        tx_rd_nxt = PW'(tx_rd_r + 1'b1);
      end
      tx_cnt_nxt = tx_cnt_r + CW'(tx_we) - CW'(tx_pop);
    end
    if (fen_chg) begin
      tx_rd_nxt = '0;
      tx_wr_nxt = '0;
      tx_cnt_nxt = '0;
    end
  end

  // Transmit engine
  usdp_state_type tx_st_r, tx_st_nxt;
  logic [15:0] tx_tm_r, tx_tm_nxt;
  logic [2:0] tx_bit_r, tx_bit_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic tx_level, ser_nxt, irn_nxt, ser_r, irn_r;

  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_tm_nxt = tx_tm_r;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt = tx_sh_r;
    tx_pop = 1'b0;
    tx_level = 1'b1;
    if (tx_tm_r != 16'h0) begin
      tx_tm_nxt = tx_tm_r - 16'h1;
    end
    case (tx_st_r)
      ST_IDLE: begin
        if (!thr_empty && !fen_chg) begin
          tx_pop = 1'b1;
          tx_sh_nxt = tx_head;
          tx_st_nxt = ST_START;
          tx_tm_nxt = BIT_LAST;
        end
      end
      ST_START: begin
        tx_level = 1'b0;
        if (tx_tm_r == 16'h0) begin
          tx_st_nxt = ST_DATA;
          tx_tm_nxt = BIT_LAST;
          tx_bit_nxt = 3'h0;
        end
      end
      ST_DATA: begin
        tx_level = tx_sh_r[0];
        if (tx_tm_r == 16'h0) begin
          tx_sh_nxt = {1'b1, tx_sh_r[7:1]};
          tx_bit_nxt = tx_bit_r + 3'h1;
          tx_tm_nxt = BIT_LAST;
          if (tx_bit_r == 3'h7) begin
            tx_st_nxt = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        if (tx_tm_r == 16'h0) begin
          tx_st_nxt = ST_IDLE;
        end
      end
      default: tx_st_nxt = ST_IDLE;
    endcase
    // Infrared sends a short low pulse at the start of each zero bit
    ser_nxt = ir_mode ? 1'b1 : tx_level; // [RULE7]
    irn_nxt = !(ir_mode && !tx_level && (tx_tm_r > IR_EDGE)); // [RULE7]
  end

  // Registers, status and read path
  logic [31:0] rdat_r, rdat_nxt;
  logic [7:0] line_status_reg;
  logic [2:0] ev;
  logic tx_idle;
  assign tx_idle = thr_empty && (tx_st_r == ST_IDLE);
  assign line_status_reg = {1'b0, tx_idle, thr_empty, 3'h0, ovr_r, rx_cnt_r != '0};
  assign ev = {tx_pop && (tx_cnt_r == ONE) && !tx_we, rx_ovr, rx_done};
  assign fen_chg = bus.wr && (bus.addr == OFF_FIFO_CTRL) &&
                   (bus.wdata[FC_FIFO_EN] != fifo_en);

  always_comb begin
    fctl_nxt = fctl_r;
    imask_nxt = imask_r;
    ist_nxt = ist_r;
    ovr_nxt = ovr_r;
    rdat_nxt = 32'h0;
    if (bus.wr && bus.addr == OFF_FIFO_CTRL) begin
      fctl_nxt = bus.wdata[1:0];
    end
    if (bus.wr && bus.addr == OFF_INT_MASK) begin
      imask_nxt = bus.wdata[2:0];
    end
    if (bus.wr && bus.addr == OFF_INT_STAT) begin
      ist_nxt = ist_r & ~bus.wdata[2:0];
    end
    if (bus.rd && bus.addr == OFF_LINE_STAT) begin
      ovr_nxt = 1'b0;
    end
    // Hardware events win over a clear in the same cycle
    ist_nxt = ist_nxt | ev;
    ovr_nxt = ovr_nxt | rx_ovr; // [RULE4] [RULE6]
    irq_nxt = |(ist_nxt & imask_nxt);
    if (bus.rd) begin
      if (win_hit) begin
        rdat_nxt = {24'h0, rx_head}; // [RULE2] [RULE13]
      end else if (bus.addr == OFF_FIFO_CTRL) begin
        rdat_nxt = {30'h0, fctl_r};
      end else if (bus.addr == OFF_LINE_STAT) begin
        rdat_nxt = {24'h0, line_status_reg};
      end else if (bus.addr == OFF_INT_STAT) begin
        rdat_nxt = {29'h0, ist_r};
      end else if (bus.addr == OFF_INT_MASK) begin
        rdat_nxt = {29'h0, imask_r};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    ser_s1_r <= serial_in;
    ser_s2_r <= ser_s1_r;
    ir_s1_r <= ir_in;
    ir_s2_r <= ir_s1_r;
    // Window reads as zero after reset, before any byte has arrived
    if (rst) begin
      rx_mem[0] <= 8'h0;
    end else if (rx_we) begin
      rx_mem[rx_wa] <= rx_sh_r;
    end
    if (tx_we) begin
      tx_mem[tx_wa] <= bus.wdata[7:0]; // [RULE13]
    end
    if (rst) begin
      fctl_r <= FIFO_CTRL_RST;
      imask_r <= INT_MASK_RST;
      ist_r <= 3'h0;
      ovr_r <= 1'b0;
      irq_r <= 1'b0;
      rdat_r <= 32'h0;
      rx_st_r <= ST_IDLE;
      rx_tm_r <= 16'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h0;
      rx_rd_r <= '0;
      rx_wr_r <= '0;
      rx_cnt_r <= '0;
      tx_st_r <= ST_IDLE;
      tx_tm_r <= 16'h0;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h0;
      tx_rd_r <= '0;
      tx_wr_r <= '0;
      tx_cnt_r <= '0;
      ser_r <= 1'b1;
      irn_r <= 1'b1;
    end else begin
      fctl_r <= fctl_nxt;
      imask_r <= imask_nxt;
      ist_r <= ist_nxt;
      ovr_r <= ovr_nxt;
      irq_r <= irq_nxt;
      rdat_r <= rdat_nxt;
      rx_st_r <= rx_st_nxt;
      rx_tm_r <= rx_tm_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_rd_r <= rx_rd_nxt;
      rx_wr_r <= rx_wr_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      tx_st_r <= tx_st_nxt;
      tx_tm_r <= tx_tm_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_rd_r <= tx_rd_nxt;
      tx_wr_r <= tx_wr_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      ser_r <= ser_nxt;
      irn_r <= irn_nxt;
    end
  end

  assign rd_data = rdat_r;
  assign serial_out = ser_r;
  assign ir_out_n = irn_r;
  assign irq = irq_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence rx_arrive_full_s;
    fifo_en && rx_done && rx_cnt_r == FULL && !rx_pop;
  endsequence
  sequence tx_launch_s;
    tx_pop && !ir_mode && !fen_chg;
  endsequence

  read_upper_zero_a: assert property ( // [RULE13]
    bus.rd |=> rd_data[31:8] == 24'h0)
    else $error("upper read bits not zero");
  window_head_a: assert property ( // [RULE1] [RULE5]
    win_rd && rx_cnt_r != '0 |=>
      rd_data[7:0] == $past(rx_head))
    else $error("window read not the receive head");
  rx_overwrite_a: assert property ( // [RULE4]
    !fifo_en && rx_done && rx_cnt_r != '0 && !rx_pop && !fen_chg |=>
      ovr_r && rx_cnt_r == ONE && rx_head == $past(rx_sh_r))
    else $error("overwrite without overrun");
  rx_full_keep_a: assert property ( // [RULE6]
    rx_arrive_full_s ##0 !fen_chg |=>
      ovr_r && rx_cnt_r == FULL && $stable(rx_wr_r))
    else $error("full receive FIFO lost contents");
  tx_holding_empty_flag_clear_a: assert property ( // [RULE9]
    !fifo_en && thr_empty && win_wr && !fen_chg |=> !thr_empty)
    else $error("write did not clear holding empty");
  tx_overwrite_a: assert property ( // [RULE10]
    !fifo_en && tx_cnt_r == ONE && win_wr && !tx_pop && !fen_chg |=>
      tx_cnt_r == ONE && tx_head == $past(bus.wdata[7:0]))
    else $error("pending byte not overwritten");
  tx_fill_a: assert property ( // [RULE11]
    fifo_en && win_wr && tx_cnt_r != FULL && !tx_pop && !fen_chg |=>
      tx_cnt_r == $past(tx_cnt_r) + ONE)
    else $error("transmit FIFO did not accept");
  tx_full_drop_a: assert property ( // [RULE12]
    fifo_en && win_wr && tx_cnt_r == FULL && !tx_pop && !fen_chg |=>
      $stable(tx_wr_r) && tx_cnt_r == FULL)
    else $error("write into full FIFO kept");
  tx_start_bit_a: assert property ( // [RULE7]
    tx_launch_s ##1 !ir_mode |=> !serial_out [*8])
    else $error("start bit not driven");
endmodule

/* File: tb/usdp_peer.sv */
// Serial line peer: sends 8N1 frames and decodes what the port transmits on serial_out
`timescale 1ns/1ps
module usdp_peer #(
  parameter int BIT = 8
) (
  input wire logic clk_sys,
  input wire logic serial_out,
  output logic serial_in,
  output logic ir_in
);
  logic [7:0] got_q[$];
  logic [7:0] b;
  logic line = 1'b1;
  // Infrared mode moves frames to ir_in, where high means a zero bit
  logic ir_on = 1'b0;

  assign serial_in = ir_on ? 1'b1 : line;
  assign ir_in = ir_on ? !line : 1'b0;

  task automatic set_ir(input logic en);
    ir_on <= en;
  endtask

  // Start, eight data bits LSB first, stop
  task automatic send(input logic [7:0] d);
    for (int i = 0; i < 10; i++) begin
      line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
      repeat (BIT) @(posedge clk_sys);
    end
  endtask

  // Mid-bit sampling; a frame with a low stop bit is not kept
  initial begin
    forever begin
      @(negedge serial_out);
      repeat (BIT / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk_sys);
        b[i] = serial_out;
      end
      repeat (BIT) @(posedge clk_sys);
      if (serial_out === 1'b1) begin
        got_q.push_back(b);
      end
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the shadow receive/transmit data window
`timescale 1ns/1ps
module tb_top;
  import usdp_pkg::*;
  // Small FIFO and short bit keep the overrun and full cases quick
  localparam int DEP = 4;
  localparam int BITC = 8;
  logic clk_sys;
  logic rst;
  usdp_bus_type bus;
  logic [31:0] rd_data;
  logic serial_in;
  logic ir_in;
  logic serial_out;
  logic ir_out_n;
  logic irq;
  int n_fail;
  int n_checks;
  int cnt;

  usdp_data_port #(.DEPTH(DEP), .CLK_PER_BIT(BITC)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .bus(bus), .rd_data(rd_data),
    .serial_in(serial_in), .ir_in(ir_in), .serial_out(serial_out),
    .ir_out_n(ir_out_n), .irq(irq)
  );

  usdp_peer #(.BIT(BITC)) u_peer (
    .clk_sys(clk_sys), .serial_out(serial_out), .serial_in(serial_in),
    .ir_in(ir_in)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Each access leaves one idle cycle so no signal is driven twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus <= '0;
    @(posedge clk_sys);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    chk(rd_data, e);
    @(posedge clk_sys);
  endtask

  task automatic cirq(input logic e);
    #1;
    chk({31'h0, irq}, {31'h0, e});
    @(posedge clk_sys);
  endtask

  task automatic wait_tx(input int n);
    cnt = 0;
    while (u_peer.got_q.size() < n) begin
      @(posedge clk_sys);
      cnt++;
      if (cnt > 3000) begin
        n_fail++;
        finish_test();
      end
    end
  endtask

  initial begin
    #5000000;
    n_fail++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    bus = '0;
    n_fail = 0;
    n_checks = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rchk(OFF_WIN_FIRST, 32'h0);
    rchk(OFF_LINE_STAT, 32'h60);
    rchk(8'h80, 32'h0);
    u_peer.send(8'ha5);
    repeat (4) @(posedge clk_sys);
    rchk(OFF_LINE_STAT, 32'h61);
    rchk(OFF_WIN_LAST, 32'ha5);
    rchk(OFF_LINE_STAT, 32'h60);
    cirq(1'b0);
    wr(OFF_INT_MASK, 32'h2);
    u_peer.send(8'h11);
    u_peer.send(8'h22);
    repeat (4) @(posedge clk_sys);
    cirq(1'b1);
    rchk(OFF_LINE_STAT, 32'h63);
    rchk(OFF_LINE_STAT, 32'h61);
    rchk(8'h08, 32'h22);
    rchk(OFF_INT_STAT, 32'h3);
    wr(OFF_INT_STAT, 32'h7);
    cirq(1'b0);
    rchk(OFF_INT_STAT, 32'h0);
    // Second write lands while the shifter is busy with the first
    u_peer.got_q.delete();
    wr(8'h04, 32'hffffff3c);
    wr(8'h0c, 32'hb1);
    rchk(OFF_LINE_STAT, 32'h00);
    wr(8'h10, 32'hc2);
    wait_tx(2);
    chk(32'(u_peer.got_q[0]), 32'h3c);
    chk(32'(u_peer.got_q[1]), 32'hc2);
    repeat (2 * BITC) @(posedge clk_sys);
    wr(OFF_FIFO_CTRL, 32'h1);
    u_peer.got_q.delete();
    for (int i = 0; i < DEP + 3; i++) begin
      wr(8'(4 * i), 32'(i));
    end
    wait_tx(DEP + 1);
    repeat (30 * BITC) @(posedge clk_sys);
    chk(32'(u_peer.got_q.size()), 32'(DEP + 1));
    for (int i = 0; i <= DEP; i++) begin
      chk(32'(u_peer.got_q[i]), 32'(i));
    end
    for (int i = 0; i <= DEP; i++) begin
      u_peer.send(8'h30 + 8'(i));
    end
    repeat (4) @(posedge clk_sys);
    rchk(OFF_LINE_STAT, 32'h63);
    for (int i = 0; i < DEP; i++) begin
      rchk(8'(16 * i + 4), 32'h30 + 32'(i));
    end
    rchk(OFF_LINE_STAT, 32'h60);
    wr(OFF_FIFO_CTRL, 32'h2);
    wr(OFF_WIN_FIRST, 32'h0f);
    // Serial line must stay high for the whole infrared frame
    cnt = 0;
    repeat (12 * BITC) begin
      @(posedge clk_sys);
      #1;
      if (ir_out_n === 1'b0) begin
        cnt++;
      end
      if (serial_out !== 1'b1) begin
        cnt = cnt + 100;
      end
    end
    chk(32'(cnt), 32'(5 * IR_PULSE_CYC));
    // Infrared receive: the frame comes on ir_in while serial_in idles
    @(posedge clk_sys);
    u_peer.set_ir(1'b1);
    u_peer.send(8'h5a);
    repeat (4) @(posedge clk_sys);
    rchk(OFF_LINE_STAT, 32'h61);
    rchk(OFF_WIN_FIRST, 32'h5a);
    finish_test();
  end
endmodule
